/* File: src/dcfft_top.sv */
module dcfft_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [dcfft_pkg::DATA_W-1:0] wr_data,
  input wire logic write_enable_primary_n,
  input wire logic write_enable_second_or_load,
  input wire logic read_enable_primary_n,
  input wire logic read_enable_second_n,
  input wire logic output_enable_n,
  output logic [dcfft_pkg::DATA_W-1:0] rd_data,
  output logic rd_data_oe,
  output logic full_flag_n,
  output logic empty_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dcfft_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int CW = dcfft_pkg::CNT_W;
  localparam int EW = dcfft_pkg::EG_LVL_W;
  localparam logic [CW-1:0] DEPTH_CNT = CW'(dcfft_pkg::FIFO_DEPTH);

  logic mode_second_ff;
  logic load_sel_ff;
  logic [CW-1:0] ae_off_ff;
  logic [CW-1:0] af_off_ff;
  logic [CW-1:0] count_ff;
  logic full_n_ff;
  logic empty_n_ff;
  logic ae_n_ff;
  logic af_n_ff;
  logic [dcfft_pkg::DATA_W-1:0] rd_data_ff;
  logic oe_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;

  logic wr_req;
  logic load_wr;
  logic rd_req;
  logic wr_push;
  logic rd_pop;
  logic core_in_ready;
  logic core_out_valid;
  logic eg_in_ready;
  logic eg_out_valid;
  logic eg_push;
  logic [dcfft_pkg::DATA_W-1:0] core_out_data;
  logic [dcfft_pkg::DATA_W-1:0] eg_out_data;
  logic [EW-1:0] eg_level;
  logic apb_access;
  logic apb_wr;
  logic apb_hit;
  logic [31:0] status_word;
  logic [CW-1:0] cnt_after_wr;
  logic [CW-1:0] cnt_after_rd;
  logic nxt_full_n;
  logic nxt_empty_n;
  logic nxt_ae_n;
  logic nxt_af_n;

  // port decode; in load mode a low second pin steers writes to the offsets
  assign wr_req = !write_enable_primary_n && write_enable_second_or_load;
  assign load_wr = !mode_second_ff && !write_enable_primary_n && !write_enable_second_or_load;
  assign rd_req = !read_enable_primary_n && !read_enable_second_n;
  assign wr_push = wr_req && full_n_ff && core_in_ready;
  assign rd_pop = rd_req && empty_n_ff && eg_out_valid;
  assign eg_push = core_out_valid && eg_in_ready;

  // main store, depth set by the package constant
  dcfft_fifo #(
    .WIDTH(dcfft_pkg::DATA_W),
    .DEPTH(dcfft_pkg::CORE_DEPTH),
    .LVL_W(dcfft_pkg::CORE_LVL_W)
  ) u_core (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .in_valid(wr_push),
    .in_ready(core_in_ready),
    .in_data(wr_data),
    .out_valid(core_out_valid),
    .out_ready(eg_in_ready),
    .out_data(core_out_data),
    .level()
  );

  // egress buffer; a stalled consumer fills it and back-pressures the store
  dcfft_fifo #(
    .WIDTH(dcfft_pkg::DATA_W),
    .DEPTH(dcfft_pkg::EGRESS_DEPTH),
    .LVL_W(EW)
  ) u_egress (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .in_valid(core_out_valid),
    .in_ready(eg_in_ready),
    .in_data(core_out_data),
    .out_valid(eg_out_valid),
    .out_ready(rd_pop),
    .out_data(eg_out_data),
    .level(eg_level)
  );

  // sync reset only, so free-running clocks during reset are harmless
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mode_second_ff <= write_enable_second_or_load;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      count_ff <= '0;
    end
    else if (ce)
    begin
      count_ff <= count_ff + CW'(wr_push) - CW'(rd_pop);
    end
  end

  // each flag sees its own port at once; full and the almost flags see the far port one edge late, empty sees writes two edges late
  always_comb
  begin
    cnt_after_wr = count_ff + CW'(wr_push);
    cnt_after_rd = count_ff - CW'(rd_pop);
    nxt_full_n = (cnt_after_wr != DEPTH_CNT);
    nxt_empty_n = ((eg_level - EW'(rd_pop)) != '0);
    nxt_ae_n = (cnt_after_rd >= ae_off_ff);
    nxt_af_n = (cnt_after_wr <= DEPTH_CNT - af_off_ff);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      full_n_ff <= 1'b1;
      empty_n_ff <= 1'b0;
      ae_n_ff <= 1'b0;
      af_n_ff <= 1'b1;
    end
    else if (ce)
    begin
      full_n_ff <= nxt_full_n;
      empty_n_ff <= nxt_empty_n;
      ae_n_ff <= nxt_ae_n;
      af_n_ff <= nxt_af_n;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rd_data_ff <= '0;
      oe_ff <= 1'b0;
    end
    else if (ce)
    begin
      oe_ff <= !output_enable_n;
      if (rd_pop)
      begin
        rd_data_ff <= eg_out_data;
      end
    end
  end

  // offsets: apb wins over a pin load in the same cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ae_off_ff <= dcfft_pkg::OFFSET_RESET;
      af_off_ff <= dcfft_pkg::OFFSET_RESET;
    end
    else if (ce)
    begin
      if (apb_wr && paddr == dcfft_pkg::ADDR_AE_OFFSET)
      begin
        ae_off_ff <= pwdata[CW-1:0];
      end
      else if (apb_wr && paddr == dcfft_pkg::ADDR_AF_OFFSET)
      begin
        af_off_ff <= pwdata[CW-1:0];
      end
      else if (load_wr && !load_sel_ff)
      begin
        ae_off_ff <= wr_data[CW-1:0];
      end
      else if (load_wr)
      begin
        af_off_ff <= wr_data[CW-1:0];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      load_sel_ff <= 1'b0;
    end
    else if (ce && load_wr && !apb_wr)
    begin
      load_sel_ff <= !load_sel_ff;
    end
  end

  // apb slave: one wait state so pready and prdata come from flops
  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pready_ff && pwrite;
  assign apb_hit = (paddr == dcfft_pkg::ADDR_AE_OFFSET) || (paddr == dcfft_pkg::ADDR_AF_OFFSET)
    || (paddr == dcfft_pkg::ADDR_STATUS);

  always_comb
  begin
    status_word = '0;
    status_word[dcfft_pkg::ST_EMPTY_N] = empty_n_ff;
    status_word[dcfft_pkg::ST_AEMPTY_N] = ae_n_ff;
    status_word[dcfft_pkg::ST_AFULL_N] = af_n_ff;
    status_word[dcfft_pkg::ST_FULL_N] = full_n_ff;
    status_word[dcfft_pkg::ST_MODE_SECOND] = mode_second_ff;
    status_word[dcfft_pkg::ST_COUNT_LSB +: CW] = count_ff;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else if (ce)
    begin
      pready_ff <= apb_access && !pready_ff;
      pslverr_ff <= apb_access && !pready_ff && !apb_hit;
      prdata_ff <= '0;
      if (apb_access && !pready_ff && !pwrite)
      begin
        unique case (paddr)
          dcfft_pkg::ADDR_AE_OFFSET: prdata_ff <= 32'(ae_off_ff);
          dcfft_pkg::ADDR_AF_OFFSET: prdata_ff <= 32'(af_off_ff);
          dcfft_pkg::ADDR_STATUS: prdata_ff <= status_word;
          default: prdata_ff <= '0;
        endcase
      end
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_data_oe = oe_ff;
  assign full_flag_n = full_n_ff;
  assign empty_flag_n = empty_n_ff;
  assign almost_empty_flag_n = ae_n_ff;
  assign almost_full_flag_n = af_n_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // a single clock means every far-port edge falls inside the gap limit
  localparam int GAP1_CYC = dcfft_pkg::EDGE_GAP_PRIMARY_CYC;
  localparam int GAP2_CYC = dcfft_pkg::EDGE_GAP_PARTIAL_CYC;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst || !ce);

  property p_full_ignores;
    !full_n_ff && wr_req && !rd_pop |=> count_ff == $past(count_ff);
  endproperty
  a_full_ignores: assert property (p_full_ignores) else $error("write taken while full");

  property p_empty_ignores;
    !empty_n_ff && rd_req |=> rd_data_ff == $past(rd_data_ff);
  endproperty
  a_empty_ignores: assert property (p_empty_ignores) else $error("read taken while empty");

  property p_full_defer;
    !full_n_ff && count_ff == DEPTH_CNT && rd_pop |=> !full_n_ff ##1 full_n_ff;
  endproperty
  a_full_defer: assert property (p_full_defer) else $error("full flag release mistimed");

  property p_empty_defer;
    !empty_n_ff && eg_level == '0 && eg_push |=> !empty_n_ff ##1 empty_n_ff;
  endproperty
  a_empty_defer: assert property (p_empty_defer) else $error("empty flag release mistimed");

  property p_ae_assert;
    count_ff == ae_off_ff && rd_pop && !wr_push ##1 ae_off_ff == $past(ae_off_ff)
      |-> !ae_n_ff;
  endproperty
  a_ae_assert: assert property (p_ae_assert) else $error("almost-empty not low");

  property p_ae_write_late;
    count_ff == ae_off_ff - 1'b1 && wr_push && !rd_pop && ae_off_ff != '0 ##1 !rd_pop
      |-> !ae_n_ff ##[1:GAP2_CYC] ae_n_ff;
  endproperty
  a_ae_write_late: assert property (p_ae_write_late) else $error("almost-empty not deferred");

  property p_af_assert;
    count_ff == DEPTH_CNT - af_off_ff && wr_push && !rd_pop |=> !af_n_ff;
  endproperty
  a_af_assert: assert property (p_af_assert) else $error("almost-full not low");

  property p_af_read_late;
    count_ff == DEPTH_CNT - af_off_ff + 1'b1 && rd_pop && !wr_push && !af_n_ff ##1 !wr_push
      |-> !af_n_ff ##[1:GAP2_CYC] af_n_ff;
  endproperty
  a_af_read_late: assert property (p_af_read_late) else $error("almost-full not deferred");

  property p_first_word;
    $rose(empty_n_ff) && rd_req |=> rd_data_ff == $past(eg_out_data) ##[0:GAP1_CYC] 1'b1;
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word not presented");

  property p_reset_state;
    $past(rst) && !rst |-> rd_data_ff == '0 && ae_off_ff == dcfft_pkg::OFFSET_RESET
      && af_off_ff == dcfft_pkg::OFFSET_RESET && mode_second_ff == $past(write_enable_second_or_load);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

  property p_apb_err;
    pready_ff && psel && penable && !apb_hit |-> pslverr_ff && prdata_ff == '0;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("unmapped access not flagged");

  c_full: cover property (!full_n_ff);
  c_first_word: cover property ($rose(empty_n_ff) && rd_pop);
  c_load: cover property (load_wr ##1 load_wr);
  c_status_rd: cover property (pready_ff && !pwrite && paddr == dcfft_pkg::ADDR_STATUS);

endmodule

/* File: src/dcfft_pkg.sv */
package dcfft_pkg;

  // storage depth: legal builds are 64, 256, 512, 1024, 2048, 4096 or 8192 words
  localparam int FIFO_DEPTH = 64;
  localparam int DATA_W = 9;
  localparam int EGRESS_DEPTH = 8;
  localparam int CORE_DEPTH = FIFO_DEPTH - EGRESS_DEPTH;
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam int CORE_LVL_W = $clog2(CORE_DEPTH + 1);
  localparam int EG_LVL_W = $clog2(EGRESS_DEPTH + 1);

  // offsets count words from the empty and the full boundary
  localparam logic [CNT_W-1:0] OFFSET_RESET = 7'h07;

  // apb map, byte addresses
  localparam int APB_ADDR_W = 12;
  localparam logic [APB_ADDR_W-1:0] ADDR_AE_OFFSET = 12'h000;
  localparam logic [APB_ADDR_W-1:0] ADDR_AF_OFFSET = 12'h004;
  localparam logic [APB_ADDR_W-1:0] ADDR_STATUS = 12'h008;

  // status field positions
  localparam int ST_EMPTY_N = 0;
  localparam int ST_AEMPTY_N = 1;
  localparam int ST_AFULL_N = 2;
  localparam int ST_FULL_N = 3;
  localparam int ST_MODE_SECOND = 4;
  localparam int ST_COUNT_LSB = 8;

  // edge gap limits in ps and their cycle counts at mclk
  localparam int MCLK_PERIOD_PS = 5000;
  localparam int EDGE_GAP_LIMIT_PRIMARY_PS = 6000;
  localparam int EDGE_GAP_LIMIT_PARTIAL_PS = 10000;
  localparam int EDGE_GAP_PRIMARY_CYC =
    (EDGE_GAP_LIMIT_PRIMARY_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int EDGE_GAP_PARTIAL_CYC =
    (EDGE_GAP_LIMIT_PARTIAL_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;

endpackage

/* File: src/dcfft_fifo.sv */
module dcfft_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8,
  parameter int LVL_W = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LVL_W-1:0] level
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [LVL_W-1:0] level_ff;
  logic push;
  logic pop;

  assign in_ready = (level_ff != FULL_LVL);
  assign out_valid = (level_ff != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_ff[rd_ptr_ff];
  assign level = level_ff;

  // no reset on the array: entries are only read once written
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge mclk)
    begin
      if (ce && push && wr_ptr_ff == PTR_W'(i))
      begin
        mem_ff[i] <= in_data;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
    end
    else if (ce && push)
    begin
      wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rd_ptr_ff <= '0;
    end
    else if (ce && pop)
    begin
      rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      level_ff <= '0;
    end
    else if (ce)
    begin
      level_ff <= level_ff + LVL_W'(push) - LVL_W'(pop);
    end
  end

endmodule

/* File: verif/dcfft_peer.sv */
module dcfft_peer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_go,
  input wire logic rd_go,
  input wire logic ignore_flags,
  input wire logic full_flag_n,
  input wire logic empty_flag_n,
  input wire logic [8:0] rd_data,
  output logic we_n,
  output logic [8:0] wr_data,
  output logic re_n,
  output logic [15:0] n_wr,
  output logic [15:0] n_rd,
  output logic [15:0] n_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_ff;
  logic [8:0] exp_ff;
  // pattern words so a cleared output never passes for data
  assign wr_data = n_wr[8:0] ^ 9'h105;
  // peers back off on the flags, unless a scenario probes refusal
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      we_n <= 1'h1;
      n_wr <= 16'h0000;
    end
    else
    begin
      if (!we_n && full_flag_n)
        n_wr <= n_wr + 16'h0001;
      we_n <= !(wr_go && (full_flag_n || ignore_flags));
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      re_n <= 1'h1;
      n_rd <= 16'h0000;
      n_bad <= 16'h0000;
      pend_ff <= 1'h0;
      exp_ff <= 9'h000;
    end
    else
    begin
      if (pend_ff && rd_data !== exp_ff)
        n_bad <= n_bad + 16'h0001;
      pend_ff <= !re_n && empty_flag_n;
      if (!re_n && empty_flag_n)
      begin
        n_rd <= n_rd + 16'h0001;
        exp_ff <= n_rd[8:0] ^ 9'h105;
      end
      re_n <= !(rd_go && (empty_flag_n || ignore_flags));
    end
  end
endmodule

/* File: verif/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic write_enable_second_or_load = 1'h1;
  logic output_enable_n = 1'h0;
  logic wr_go = 1'h0;
  logic rd_go = 1'h0;
  logic ign = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [8:0] wr_data, rd_data;
  logic we_n, re_n, rd_data_oe, pready, pslverr;
  logic full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n;
  logic [31:0] prdata, q;
  logic [15:0] n_wr, n_rd, n_bad;
  logic e;
  int n_fail = 0;
  int checked = 0;
  always #2.5 mclk = ~mclk;
  dcfft_top dut (.mclk(mclk), .rst(rst), .ce(ce), .wr_data(wr_data),
    .write_enable_primary_n(we_n), .write_enable_second_or_load(write_enable_second_or_load),
    .read_enable_primary_n(re_n), .read_enable_second_n(re_n),
    .output_enable_n(output_enable_n), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
    .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dcfft_peer peer (.mclk(mclk), .rst(rst), .wr_go(wr_go), .rd_go(rd_go),
    .ignore_flags(ign), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
    .rd_data(rd_data), .we_n(we_n), .wr_data(wr_data), .re_n(re_n),
    .n_wr(n_wr), .n_rd(n_rd), .n_bad(n_bad));
  task stop_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task tmo;
    chk("wait", 32'h0000_0000, 32'h0000_0001);
    stop_test();
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    for (i = 0; i < 50 && pready !== 1'h1; i++)
      @(posedge mclk);
    if (i == 50)
      tmo();
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  task do_reset(input logic mode);
    rst <= 1'h1;
    write_enable_second_or_load <= mode;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    write_enable_second_or_load <= 1'h1;
    repeat (2) @(posedge mclk);
  endtask
  task t_reset;
    chk("flags", {full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n},
      32'h0000_0009);
    chk("oe", rd_data_oe, 32'h0000_0001);
    chk("rd_data", rd_data, 32'h0000_0000);
    apb(1'h0, dcfft_pkg::ADDR_AE_OFFSET, 32'h0000_0000);
    chk("ae_off", q, 32'h0000_0007);
    apb(1'h0, dcfft_pkg::ADDR_AF_OFFSET, 32'h0000_0000);
    chk("af_off", q, 32'h0000_0007);
    apb(1'h0, dcfft_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("mode", q[dcfft_pkg::ST_MODE_SECOND], 32'h0000_0001);
    apb(1'h0, 12'h00C, 32'h0000_0000);
    chk("slverr", e, 32'h0000_0001);
    apb(1'h1, dcfft_pkg::ADDR_AE_OFFSET, 32'h0000_0005);
    apb(1'h0, dcfft_pkg::ADDR_AE_OFFSET, 32'h0000_0000);
    chk("ae_wr", q, 32'h0000_0005);
    apb(1'h1, dcfft_pkg::ADDR_AE_OFFSET, 32'h0000_0007);
    output_enable_n <= 1'h1;
    repeat (2) @(posedge mclk);
    chk("oe_off", rd_data_oe, 32'h0000_0000);
    output_enable_n <= 1'h0;
    @(posedge mclk);
  endtask
  task t_first;
    int i, j;
    logic [8:0] held;
    wr_go <= 1'h1;
    @(posedge mclk);
    wr_go <= 1'h0;
    for (i = 0; i < 20 && n_wr !== 16'h0001; i++)
      @(posedge mclk);
    if (i == 20)
      tmo();
    for (j = 0; j < 20 && empty_flag_n !== 1'h1; j++)
      @(posedge mclk);
    chk("latency", j, 32'h0000_0002);
    if (j == 20)
      tmo();
    rd_go <= 1'h1;
    for (i = 0; i < 20 && n_rd !== 16'h0001; i++)
      @(posedge mclk);
    if (i == 20)
      tmo();
    rd_go <= 1'h0;
    repeat (2) @(posedge mclk);
    chk("first", rd_data, 32'h0000_0105);
    held = rd_data;
    // consumer ignores the empty flag, so the design itself must refuse
    ign <= 1'h1;
    rd_go <= 1'h1;
    repeat (4) @(posedge mclk);
    chk("empty_rd", {empty_flag_n, rd_data}, {23'h00_0000, held});
    wr_go <= 1'h1;
    @(posedge mclk);
    wr_go <= 1'h0;
    for (i = 0; i < 20 && n_rd !== 16'h0002; i++)
      @(posedge mclk);
    if (i == 20)
      tmo();
    rd_go <= 1'h0;
    ign <= 1'h0;
    repeat (2) @(posedge mclk);
    chk("second", {n_bad[8:0], rd_data}, 32'h0000_0104);
  endtask
  task t_fill;
    int i;
    logic s;
    s = 1'h0;
    wr_go <= 1'h1;
    // consumer stalls, so the egress stage must fill as well
    for (i = 0; i < 200 && full_flag_n !== 1'h0; i++)
    begin
      if (!s && almost_full_flag_n === 1'h0)
      begin
        s = 1'h1;
        chk("af_lvl", 32'(n_wr - n_rd), 32'h0000_003A);
      end
      @(posedge mclk);
    end
    if (i == 200)
      tmo();
    chk("af_seen", s, 32'h0000_0001);
    chk("depth", 32'(n_wr - n_rd), 32'h0000_0040);
    ign <= 1'h1;
    repeat (6) @(posedge mclk);
    apb(1'h0, dcfft_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("cnt_full", {full_flag_n, q[14:8]}, 32'h0000_0040);
    wr_go <= 1'h0;
    ign <= 1'h0;
    rd_go <= 1'h1;
    s = 1'h0;
    for (i = 0; i < 300 && !(empty_flag_n === 1'h0 && n_rd == n_wr); i++)
    begin
      if (!s && almost_empty_flag_n === 1'h0)
      begin
        s = 1'h1;
        chk("ae_lvl", 32'(n_wr - n_rd), 32'h0000_0006);
      end
      @(posedge mclk);
    end
    if (i == 300)
      tmo();
    chk("ae_seen", s, 32'h0000_0001);
    rd_go <= 1'h0;
    repeat (2) @(posedge mclk);
    chk("order", n_bad, 32'h0000_0000);
    chk("unfull", full_flag_n, 32'h0000_0001);
  endtask
  task t_load;
    do_reset(1'h0);
    apb(1'h0, dcfft_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("mode_ld", q[dcfft_pkg::ST_MODE_SECOND], 32'h0000_0000);
    // pin low beside the primary enable: two offset loads, no writes
    wr_go <= 1'h1;
    write_enable_second_or_load <= 1'h0;
    repeat (2) @(posedge mclk);
    wr_go <= 1'h0;
    repeat (3) @(posedge mclk);
    write_enable_second_or_load <= 1'h1;
    apb(1'h0, dcfft_pkg::ADDR_AE_OFFSET, 32'h0000_0000);
    chk("ld_ae", q, 32'h0000_0005);
    apb(1'h0, dcfft_pkg::ADDR_AF_OFFSET, 32'h0000_0000);
    chk("ld_af", q, 32'h0000_0004);
    chk("ld_empty", empty_flag_n, 32'h0000_0000);
  endtask
  initial
  begin
    do_reset(1'h1);
    t_reset();
    t_first();
    t_fill();
    t_load();
    stop_test();
  end
endmodule
